// [cpu_address_generation.sv]
`timescale 1ns/10ps
`include "cpu_agen_defines.svh"
module cpu_address_generation
  import cpu_agen_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic branchValid,
  input wire branch_mode_t branchMode,
  input wire logic [19:0] nextPc,
  input wire logic [15:0] disp,
  input wire logic [19:0] immTarget,
  input wire logic [4:0] tableIndex,
  input wire logic [1:0] pairSel,
  input wire logic [2:0] regSel,
  input wire logic [63:0] regFile,
  input wire logic [3:0] codeSegment,
  input wire logic [3:0] extraSegment,
  input wire logic extraPrefix,
  input wire logic opValid,
  input wire operand_mode_t opMode,
  input wire logic isUnsignedMultiply,
  input wire logic wordAccess,
  input wire logic [15:0] opImm16,
  input wire logic [7:0] opImm8,
  input wire logic stackValid,
  input wire stack_op_t stackOp,
  input wire logic [7:0] statusWord,
  input wire logic [7:0] memRdata,
  output logic [19:0] pcOut,
  output logic pcLoad,
  output logic [19:0] opAddr,
  output logic opAddrValid,
  output logic [15:0] regPairOut,
  output logic [7:0] regByteOut,
  output logic [19:0] memAddr,
  output logic memWr,
  output logic memRd,
  output logic [7:0] memWdata,
  output logic [15:0] popData,
  output logic [7:0] statusOut,
  output logic statusLoad,
  output logic popDone,
  output logic [15:0] spOut,
  output logic busy
);
  logic [7:0] byteReg [8];
  logic [15:0] pairReg [4];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_byte
      assign byteReg[gi] = regFile[gi*8 +: 8];
    end
    for (gi = 0; gi < 4; gi++) begin : g_pair
      assign pairReg[gi] = regFile[gi*16 +: 16];
    end
  endgenerate
  logic [7:0] selByte;
  logic [15:0] selPair;
  logic [15:0] hlPair;
  assign selByte = byteReg[regSel];
  assign selPair = pairReg[pairSel];
  assign hlPair = pairReg[3];

  seq_state_t state_reg, state_next;
  stack_op_t op_reg, op_next;
  logic [15:0] sp_reg, sp_next;
  logic [19:0] pc_reg, pc_next;
  logic pcLoad_reg, pcLoad_next;
  logic [19:0] opAddr_reg, opAddr_next;
  logic opValid_reg, opValid_next;
  logic [15:0] rp_reg, rp_next;
  logic [7:0] rb_reg, rb_next;
  logic [19:0] mAddr_reg, mAddr_next;
  logic mWr_reg, mWr_next, mRd_reg, mRd_next;
  logic [7:0] mData_reg, mData_next;
  logic [15:0] pop_reg, pop_next;
  logic [7:0] st_reg, st_next;
  logic stLoad_reg, stLoad_next, popDone_reg, popDone_next;
  logic [19:0] save_reg, save_next;
  logic [7:0] psw_reg, psw_next;
  logic busy_reg, busy_next;
  logic [15:0] base;
  logic [15:0] offs;
  logic [15:0] eff16;
  logic [3:0] upper;

  always_comb begin
    base = selPair;
    offs = 16'h0000;
    eff16 = 16'h0000;
    upper = extraPrefix ? extraSegment : `TOP_REGION;
    opAddr_next = opAddr_reg;
    opValid_next = 1'b0;
    rp_next = rp_reg;
    rb_next = rb_reg;
    if (opValid) begin
      opValid_next = 1'b1;
      case (opMode)
        OP_IMPLIED: begin
          opValid_next = isUnsignedMultiply;
        end
        OP_REG: begin
          rp_next = selPair;
          rb_next = selByte;
        end
        OP_DIRECT: begin
          opAddr_next = {upper, opImm16};
        end
        OP_SHORT: begin
          opAddr_next = `SHORT_BASE + {12'h000, opImm8[7:1], opImm8[0] & ~wordAccess};
        end
        OP_SFR: begin
          opAddr_next = `SFR_BASE + {12'h000, opImm8[7:1], opImm8[0] & ~wordAccess};
        end
        OP_INDIRECT: begin
          opAddr_next = {upper, selPair};
        end
        OP_BASED_RB, OP_BASED_SP, OP_BASED_WR, OP_BASED_WW: begin
          case (opMode)
            OP_BASED_RB: begin
              base = selPair;
              offs = {8'h00, opImm8};
            end
            OP_BASED_SP: begin
              base = sp_reg;
              offs = {8'h00, opImm8};
              upper = `TOP_REGION;
            end
            OP_BASED_WR: begin
              base = opImm16;
              offs = {8'h00, selByte};
            end
            default: begin
              base = opImm16;
              offs = selPair;
            end
          endcase
          eff16 = base + offs;
          opAddr_next = {upper, eff16};
        end
        OP_INDEXED: begin
          eff16 = hlPair + {8'h00, selByte};
          opAddr_next = {upper, eff16};
        end
        default: begin
          opValid_next = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    pcLoad_next = 1'b0;
    mAddr_next = mAddr_reg;
    mWr_next = 1'b0;
    mRd_next = 1'b0;
    mData_next = mData_reg;
    pop_next = pop_reg;
    st_next = st_reg;
    stLoad_next = 1'b0;
    popDone_next = 1'b0;
    save_next = save_reg;
    psw_next = psw_reg;
    case (state_reg)
      S_IDLE: begin
        if (branchValid) begin
          pcLoad_next = 1'b1;
          case (branchMode)
            BR_REL8: pc_next = nextPc + {{12{disp[7]}}, disp[7:0]};
            BR_REL16: pc_next = nextPc + {{4{disp[15]}}, disp};
            BR_IMM20: pc_next = immTarget;
            BR_IMM16: pc_next = {`LOW_REGION, immTarget[15:0]};
            BR_REGDIR: pc_next = {codeSegment, selPair};
            BR_TABLE: begin
              pcLoad_next = 1'b0;
              mAddr_next = `TABLE_BASE + {14'h0000, tableIndex, 1'b0};
              mRd_next = 1'b1;
              state_next = S_TAB1;
            end
            default: pcLoad_next = 1'b0;
          endcase
        end else if (stackValid && stackOp != ST_NONE) begin
          op_next = stackOp;
          save_next = nextPc;
          psw_next = statusWord;
          state_next = S_B1;
        end
      end
      S_TAB1: begin
        pc_next = {`LOW_REGION, 8'h00, memRdata};
        mAddr_next = mAddr_reg + 20'h00001;
        mRd_next = 1'b1;
        state_next = S_TAB2;
      end
      S_TAB2: begin
        pc_next = {`LOW_REGION, memRdata, pc_reg[7:0]};
        pcLoad_next = 1'b1;
        state_next = S_IDLE;
      end
      S_B1, S_B2, S_B3, S_B4: begin
        case (op_reg)
          ST_PUSH, ST_PUSH_PSW: begin
            mWr_next = 1'b1;
            if (state_reg == S_B1) begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd1};
              mData_next = (op_reg == ST_PUSH_PSW) ? psw_reg : selPair[15:8];
              state_next = S_B2;
            end else begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd2};
              mData_next = (op_reg == ST_PUSH_PSW) ? `ZERO_BYTE : selPair[7:0];
              sp_next = sp_reg - 16'd2;
              state_next = S_IDLE;
            end
          end
          ST_POP, ST_POP_PSW: begin
            if (state_reg == S_B1) begin
              mAddr_next = {`TOP_REGION, sp_reg};
              mRd_next = 1'b1;
              state_next = S_B2;
            end else if (state_reg == S_B2) begin
              // read data stands in the cycle its strobe is out
              pop_next[7:0] = memRdata;
              mAddr_next = {`TOP_REGION, sp_reg + 16'd1};
              mRd_next = 1'b1;
              state_next = S_B3;
            end else begin
              pop_next[15:8] = memRdata;
              st_next = memRdata;
              stLoad_next = (op_reg == ST_POP_PSW);
              popDone_next = (op_reg == ST_POP);
              sp_next = sp_reg + 16'd2;
              state_next = S_IDLE;
            end
          end
          ST_CALL, ST_INTR: begin
            mWr_next = 1'b1;
            if (state_reg == S_B1) begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd1};
              mData_next = psw_reg;
              mWr_next = (op_reg == ST_INTR);
              state_next = S_B2;
            end else if (state_reg == S_B2) begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd2};
              mData_next = {4'h0, save_reg[19:16]};
              state_next = S_B3;
            end else if (state_reg == S_B3) begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd3};
              mData_next = save_reg[15:8];
              state_next = S_B4;
            end else begin
              mAddr_next = {`TOP_REGION, sp_reg - 16'd4};
              mData_next = save_reg[7:0];
              sp_next = sp_reg - 16'd4;
              state_next = S_IDLE;
            end
          end
          default: begin
            // plain and interrupt returns read PC bytes
            // reads pipelined one cycle; read address issued, data used next state
            mRd_next = 1'b1;
            if (state_reg == S_B1) begin
              mAddr_next = {`TOP_REGION, sp_reg};
              state_next = S_B2;
            end else if (state_reg == S_B2) begin
              pc_next[7:0] = memRdata;
              mAddr_next = {`TOP_REGION, sp_reg + 16'd1};
              state_next = S_B3;
            end else if (state_reg == S_B3) begin
              pc_next[15:8] = memRdata;
              mAddr_next = {`TOP_REGION, sp_reg + 16'd2};
              state_next = S_B4;
            end else begin
              pc_next[19:16] = memRdata[3:0];
              mAddr_next = {`TOP_REGION, sp_reg + 16'd3};
              state_next = (op_reg == ST_INTERRUPT_RETURN) ? S_TAB2 : S_IDLE;
              op_next = ST_NONE;
              pcLoad_next = (op_reg != ST_INTERRUPT_RETURN);
              sp_next = sp_reg + 16'd4;
              mRd_next = (op_reg == ST_INTERRUPT_RETURN);
            end
          end
        endcase
      end
      default: state_next = S_IDLE;
    endcase
    // status byte of interrupt return arrives in the table-finish slot
    if (state_reg == S_TAB2 && op_reg == ST_NONE && !mRd_reg) begin
      pc_next = pc_reg;
    end
    if (state_reg == S_TAB2 && mRd_reg && mAddr_reg[15:0] == sp_reg - 16'd1) begin
      pc_next = pc_reg;
      st_next = memRdata;
      stLoad_next = 1'b1;
    end
    // busy kept in a flop so the port is registered
    busy_next = (state_next != S_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      op_reg <= ST_NONE;
      sp_reg <= `SP_RESET;
      pc_reg <= `PC_RESET;
      pcLoad_reg <= 1'b0;
      opAddr_reg <= 20'h00000;
      opValid_reg <= 1'b0;
      rp_reg <= 16'h0000;
      rb_reg <= 8'h00;
      mAddr_reg <= 20'h00000;
      mWr_reg <= 1'b0;
      mRd_reg <= 1'b0;
      mData_reg <= 8'h00;
      pop_reg <= 16'h0000;
      st_reg <= 8'h00;
      stLoad_reg <= 1'b0;
      popDone_reg <= 1'b0;
      save_reg <= 20'h00000;
      psw_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      pcLoad_reg <= pcLoad_next;
      opAddr_reg <= opAddr_next;
      opValid_reg <= opValid_next;
      rp_reg <= rp_next;
      rb_reg <= rb_next;
      mAddr_reg <= mAddr_next;
      mWr_reg <= mWr_next;
      mRd_reg <= mRd_next;
      mData_reg <= mData_next;
      pop_reg <= pop_next;
      st_reg <= st_next;
      stLoad_reg <= stLoad_next;
      popDone_reg <= popDone_next;
      save_reg <= save_next;
      psw_reg <= psw_next;
      busy_reg <= busy_next;
    end
  end

  assign pcOut = pc_reg;
  assign pcLoad = pcLoad_reg;
  assign opAddr = opAddr_reg;
  assign opAddrValid = opValid_reg;
  assign regPairOut = rp_reg;
  assign regByteOut = rb_reg;
  assign memAddr = mAddr_reg;
  assign memWr = mWr_reg;
  assign memRd = mRd_reg;
  assign memWdata = mData_reg;
  assign popData = pop_reg;
  assign statusOut = st_reg;
  assign statusLoad = stLoad_reg;
  assign popDone = popDone_reg;
  assign spOut = sp_reg;
  assign busy = busy_reg;
endmodule

// [cpu_agen_defines.svh]
`ifndef CPU_AGEN_DEFINES_SVH
`define CPU_AGEN_DEFINES_SVH
`define TOP_REGION 4'hF
`define LOW_REGION 4'h0
`define SHORT_BASE 20'hFFE20
`define SFR_BASE 20'hFFF00
`define TABLE_BASE 20'h00080
`define ZERO_BYTE 8'h00
`define SP_RESET 16'hFEE0
`define PC_RESET 20'h00000
`endif

// [cpu_agen_pkg.sv]
package cpu_agen_pkg;
  typedef enum logic [2:0] {
    BR_REL8, BR_REL16, BR_IMM20, BR_IMM16, BR_TABLE, BR_REGDIR, BR_NONE
  } branch_mode_t;
  typedef enum logic [3:0] {
    OP_IMPLIED, OP_REG, OP_DIRECT, OP_SHORT, OP_SFR, OP_INDIRECT,
    OP_BASED_RB, OP_BASED_SP, OP_BASED_WR, OP_BASED_WW, OP_INDEXED, OP_NONE
  } operand_mode_t;
  typedef enum logic [3:0] {
    ST_NONE, ST_PUSH, ST_PUSH_PSW, ST_POP, ST_POP_PSW, ST_CALL,
    ST_INTR, ST_RET, ST_INTERRUPT_RETURN
  } stack_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_B1, S_B2, S_B3, S_B4, S_TAB1, S_TAB2
  } seq_state_t;
endpackage

// [cpu_address_generation_asserts.sv]
`timescale 1ns/10ps
module cpu_address_generation_asserts
  import cpu_agen_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic branchValid,
  input wire branch_mode_t branchMode,
  input wire logic [19:0] nextPc,
  input wire logic [15:0] disp,
  input wire logic [19:0] immTarget,
  input wire logic [4:0] tableIndex,
  input wire logic [1:0] pairSel,
  input wire logic [63:0] regFile,
  input wire logic [3:0] codeSegment,
  input wire logic [3:0] extraSegment,
  input wire logic extraPrefix,
  input wire logic opValid,
  input wire operand_mode_t opMode,
  input wire logic isUnsignedMultiply,
  input wire logic wordAccess,
  input wire logic [15:0] opImm16,
  input wire logic [7:0] opImm8,
  input wire logic stackValid,
  input wire stack_op_t stackOp,
  input wire logic [19:0] pcOut,
  input wire logic pcLoad,
  input wire logic [19:0] opAddr,
  input wire logic opAddrValid,
  input wire logic [19:0] memAddr,
  input wire logic memWr,
  input wire logic memRd,
  input wire logic [7:0] memWdata,
  input wire logic [15:0] spOut,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic brGo;
  logic opGo;
  assign brGo = branchValid && !busy;
  assign opGo = opValid && !isUnsignedMultiply;
  chk_rel8_target: assert property (brGo && branchMode == BR_REL8 |=> pcLoad &&
    pcOut == $past(nextPc) + {{12{$past(disp[7])}}, $past(disp[7:0])}) else $error("rel8 bad");
  chk_imm16_zero: assert property (brGo && branchMode == BR_IMM16 |=>
    pcLoad && pcOut == {4'h0, $past(immTarget[15:0])}) else $error("imm16 bad");
  chk_table_fetch: assert property (brGo && branchMode == BR_TABLE |=> memRd &&
    memAddr == 20'h00080 + {$past(tableIndex), 1'b0} ##2 pcLoad && pcOut[19:16] == 4'h0)
    else $error("table call bad");
  chk_regdir_target: assert property (brGo && branchMode == BR_REGDIR |=>
    pcOut == {$past(codeSegment), $past(regFile[pairSel*16 +: 16])}) else $error("regdir bad");
  chk_operand_no_pc: assert property (opValid && !branchValid && !busy |=> !pcLoad)
    else $error("pc loaded by operand");
  chk_implied_gate: assert property (opValid && opMode == OP_IMPLIED && !isUnsignedMultiply
    |=> !opAddrValid) else $error("implied bad");
  chk_direct_region: assert property (opGo && opMode == OP_DIRECT |=> opAddrValid &&
    opAddr == {($past(extraPrefix) ? $past(extraSegment) : 4'hF), $past(opImm16)})
    else $error("direct bad");
  chk_short_window: assert property (opGo && opMode == OP_SHORT && !wordAccess |=>
    opAddr == 20'hFFE20 + {12'h000, $past(opImm8)}) else $error("short bad");
  chk_sfr_even: assert property (opGo && opMode == OP_SFR && wordAccess |=>
    opAddr == {12'hFFF, $past(opImm8[7:1]), 1'b0}) else $error("sfr bad");
  chk_push_order: assert property (stackValid && !busy && !branchValid && stackOp == ST_PUSH
    |-> ##2 memWr && memAddr == {4'hF, $past(spOut, 2) - 16'h1}
    ##1 memWr && memAddr == {4'hF, $past(spOut, 3) - 16'h2}) else $error("push bad");
  chk_call_high: assert property (stackValid && !busy && !branchValid && stackOp == ST_CALL
    |-> ##3 memWr && memAddr == {4'hF, $past(spOut, 3) - 16'h2} &&
    memWdata == {4'h0, $past(nextPc[19:16], 3)}) else $error("call bad");
  cover property (pcLoad && branchMode == BR_TABLE);
  cover property (memWr && stackOp == ST_INTR);
  cover property (opAddrValid && extraPrefix);
endmodule

// [cpu_agen_mem.sv]
`timescale 1ns/10ps
module cpu_agen_mem (
  input wire logic ref_clk,
  input wire logic [19:0] memAddr,
  input wire logic memWr,
  input wire logic memRd,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  logic [7:0] store [logic [19:0]];
  initial memRdata = 8'h00;
  always @(posedge ref_clk) begin
    if (memWr === 1'b1) store[memAddr] = memWdata;
  end
  // read answers in the cycle the strobe stands; unwritten bytes give an address pattern
  always @(negedge ref_clk) begin
    if (memRd === 1'b1) memRdata <= store.exists(memAddr) ? store[memAddr] : memAddr[7:0] ^ 8'h5A;
    else memRdata <= ~memRdata;
  end
endmodule

// [cpu_address_generation_bench.sv]
`timescale 1ns/10ps
`define CHK(a,b) begin expV = b; gotV = a; compares++; if (gotV !== expV) begin miscompares++; \
  $display("[ERR] %0t got=%h exp=%h", $time, gotV, expV); end end
module cpu_address_generation_bench;
  import cpu_agen_pkg::*;
  logic ref_clk = 0, reset_n = 0, branchValid = 0, extraPrefix = 0, opValid = 0, stackValid = 0;
  logic isUnsignedMultiply = 0, wordAccess = 0, pcLoad, opAddrValid, memWr, memRd, statusLoad;
  logic popDone, busy;
  branch_mode_t branchMode = BR_NONE;
  operand_mode_t opMode = OP_NONE;
  stack_op_t stackOp = ST_NONE;
  logic [19:0] nextPc = 0, immTarget = 0, pcOut, opAddr, memAddr;
  logic [15:0] disp = 0, opImm16 = 0, regPairOut, popData, spOut, lastPair, sp, d;
  logic [63:0] regFile = 0;
  logic [4:0] tableIndex = 0;
  logic [3:0] codeSegment = 0, extraSegment = 0;
  logic [2:0] regSel = 0;
  logic [1:0] pairSel = 0;
  logic [7:0] opImm8 = 0, statusWord = 0, memRdata, memWdata, regByteOut, statusOut;
  logic [19:0] pcQ[$], opQ[$];
  logic [7:0] mirror [logic [15:0]];
  logic [27:0] wrQ[$];
  logic [15:0] popQ[$];
  logic [7:0] stQ[$];
  logic [31:0] expV, gotV;
  int seed = 7, compares = 0, miscompares = 0, cycles = 0;
  cpu_address_generation u_cpu_address_generation (.ref_clk, .reset_n, .branchValid, .branchMode,
    .nextPc, .disp, .immTarget, .tableIndex, .pairSel, .regSel, .regFile, .codeSegment,
    .extraSegment, .extraPrefix, .opValid, .opMode, .isUnsignedMultiply, .wordAccess, .opImm16,
    .opImm8, .stackValid, .stackOp, .statusWord, .memRdata, .pcOut, .pcLoad, .opAddr,
    .opAddrValid, .regPairOut, .regByteOut, .memAddr, .memWr, .memRd, .memWdata, .popData,
    .statusOut, .statusLoad, .popDone, .spOut, .busy);
  cpu_agen_mem u_cpu_agen_mem (.ref_clk, .memAddr, .memWr, .memRd, .memWdata, .memRdata);
  initial forever #12.5 ref_clk = ~ref_clk;
  function logic [15:0] pairV(logic [1:0] p);
    return regFile[p*16 +: 16];
  endfunction
  function logic [15:0] byteV(logic [2:0] r);
    return {8'h00, regFile[r*8 +: 8]};
  endfunction
  function logic [19:0] pcExp();
    logic [19:0] e;
    e = 20'h00080 + {tableIndex, 1'b0};
    case (branchMode)
      BR_REL8: return nextPc + {{12{disp[7]}}, disp[7:0]};
      BR_REL16: return nextPc + {{4{disp[15]}}, disp};
      BR_IMM20: return immTarget;
      BR_IMM16: return {4'h0, immTarget[15:0]};
      BR_TABLE: return {4'h0, (e[7:0] + 8'h1) ^ 8'h5A, e[7:0] ^ 8'h5A};
      default: return {codeSegment, pairV(pairSel)};
    endcase
  endfunction
  function logic [19:0] opExp();
    logic [15:0] s;
    logic [3:0] up;
    up = extraPrefix ? extraSegment : 4'hF;
    case (opMode)
      OP_DIRECT: s = opImm16;
      OP_INDIRECT: s = pairV(pairSel);
      OP_BASED_RB: s = pairV(pairSel) + {8'h00, opImm8};
      OP_BASED_SP: begin s = spOut + {8'h00, opImm8}; up = 4'hF; end
      OP_BASED_WR: s = opImm16 + byteV(regSel);
      OP_BASED_WW: s = opImm16 + pairV(pairSel);
      OP_INDEXED: s = pairV(2'd3) + byteV(regSel);
      OP_SHORT: return (20'hFFE20 + {12'h000, opImm8}) & {19'h7FFFF, ~wordAccess};
      default: return {12'hFFF, opImm8[7:1], opImm8[0] & ~wordAccess};
    endcase
    return {up, s};
  endfunction
  function void wr(logic [15:0] a, logic [7:0] b);
    wrQ.push_back({4'hF, a, b});
    mirror[a] = b;
  endfunction
  task scramble();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    regFile <= r;
    r = {$random(seed), $random(seed)};
    {nextPc, disp, immTarget, pairSel, regSel} <= r[60:0];
    r = {$random(seed), $random(seed)};
    {codeSegment, extraSegment, opImm16, opImm8, statusWord} <= r[39:0];
  endtask
  task kick(int k);
    @(negedge ref_clk);
    while (busy !== 1'b0) @(negedge ref_clk);
    sp = spOut;
    d = 16'h0;
    if (k == 0) pcQ.push_back(pcExp());
    else if (k == 1 && opMode != OP_REG && opMode != OP_IMPLIED) opQ.push_back(opExp());
    else if (k == 2) begin
      case (stackOp)
        ST_PUSH, ST_PUSH_PSW: begin
          lastPair = (stackOp == ST_PUSH) ? pairV(pairSel) : {statusWord, 8'h00};
          wr(sp - 16'h1, lastPair[15:8]);
          wr(sp - 16'h2, lastPair[7:0]);
          d = 16'hFFFE;
        end
        ST_POP: begin popQ.push_back({mirror[sp + 16'h1], mirror[sp]}); d = 16'h2; end
        ST_POP_PSW: begin stQ.push_back(mirror[sp + 16'h1]); d = 16'h2; end
        ST_CALL, ST_INTR: begin
          if (stackOp == ST_INTR) wr(sp - 16'h1, statusWord);
          wr(sp - 16'h2, {4'h0, nextPc[19:16]});
          wr(sp - 16'h3, nextPc[15:8]);
          wr(sp - 16'h4, nextPc[7:0]);
          d = 16'hFFFC;
        end
        default: begin
          // return frames come back from the bytes earlier frames laid down
          pcQ.push_back({mirror[sp + 16'h2][3:0], mirror[sp + 16'h1], mirror[sp]});
          if (stackOp == ST_INTERRUPT_RETURN) stQ.push_back(mirror[sp + 16'h3]);
          d = 16'h4;
        end
      endcase
    end
    @(posedge ref_clk);
    if (k == 0) branchValid <= 1'b1;
    else if (k == 1) opValid <= 1'b1;
    else stackValid <= 1'b1;
    @(posedge ref_clk);
    {branchValid, opValid, stackValid} <= 3'b000;
    repeat (9) @(posedge ref_clk);
    if (k == 2) `CHK(spOut, 16'(sp + d))
  endtask
  task wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // results are matched in issue order at the settled half of the cycle
  always @(negedge ref_clk) if (reset_n) begin
    if (pcLoad === 1'b1) `CHK(pcOut, pcQ.pop_front())
    if (opAddrValid === 1'b1) begin
      // register forms and implied forms with isUnsignedMultiply carry no address, only the valid pulse
      if (opMode == OP_REG || opMode == OP_IMPLIED)
        `CHK(opMode == OP_REG || isUnsignedMultiply, 1'b1)
      else
        `CHK(opAddr, opQ.pop_front())
    end
    if (memWr === 1'b1) `CHK({memAddr, memWdata}, wrQ.pop_front())
    if (popDone === 1'b1 && stackOp == ST_POP) `CHK(popData, popQ.pop_front())
    if (statusLoad === 1'b1) `CHK(statusOut, stQ.pop_front())
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    `CHK(spOut, 16'hFEE0)
    `CHK(pcOut, 20'h00000)
    for (int i = 0; i < 12; i++) begin
      scramble();
      branchMode <= branch_mode_t'(i % 6);
      tableIndex <= (i > 6) ? 5'h1F : 5'h00;
      kick(0);
    end
    $display("branch targets done");
    for (int j = 0; j < 2; j++) begin
      for (int m = 2; m < 11; m++) begin
        scramble();
        opMode <= operand_mode_t'(m);
        extraPrefix <= j[0];
        wordAccess <= j[0];
        kick(1);
      end
    end
    scramble();
    opMode <= OP_REG;
    kick(1);
    `CHK(regByteOut, byteV(regSel))
    `CHK(regPairOut, pairV(pairSel))
    opMode <= OP_IMPLIED;
    kick(1);
    isUnsignedMultiply <= 1'b1;
    kick(1);
    $display("operand addresses done");
    for (int i = 1; i < 9; i++) begin
      scramble();
      stackOp <= stack_op_t'(i);
      kick(2);
    end
    $display("stack frames done");
    repeat (4) @(posedge ref_clk);
    `CHK(pcQ.size() + opQ.size() + wrQ.size() + popQ.size() + stQ.size(), 0)
    wrap_up();
  end
endmodule
bind cpu_address_generation cpu_address_generation_asserts u_cpu_address_generation_asserts (
  .ref_clk, .reset_n, .branchValid, .branchMode, .nextPc, .disp, .immTarget, .tableIndex,
  .pairSel, .regFile, .codeSegment, .extraSegment, .extraPrefix, .opValid, .opMode,
  .isUnsignedMultiply, .wordAccess, .opImm16, .opImm8, .stackValid, .stackOp, .pcOut, .pcLoad,
  .opAddr, .opAddrValid, .memAddr, .memWr, .memRd, .memWdata, .spOut, .busy);
